/* File: interrupt_priority_config.sv */
// priority level registers and per-source level outputs
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "prio_map.svh"
module interrupt_priority_config
  import prio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  output logic [7:0] rdata,
  output logic [1:0] ext0_level,
  output logic [1:0] timer0_level,
  output logic [1:0] ext1_level,
  output logic [1:0] timer1_level,
  output logic [1:0] serial_level
);
  prio_reg_if rif ();
  access_e acc;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [9:0] lvl_d;
  logic [9:0] lvl_q;

  prio_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  // address decode; reserved bits 7..5 are dropped on write
  always_comb begin
    acc = acc_none;
    if (wr) begin
      acc = acc_byte;
    end else if (bit_wr) begin
      acc = acc_bit;
    end
  end

  assign rif.wdata = wdata[4:0];
  assign rif.wr_hi = (acc == acc_byte) && (addr == `PRIO_HI_ADDR);
  assign rif.wr_lo = (acc == acc_byte) && (addr == `PRIO_LO_ADDR);
  assign rif.bit_wr_lo = (acc == acc_bit) && (addr == `PRIO_LO_ADDR);
  assign rif.bit_sel = bit_sel;
  assign rif.bit_val = bit_val;

  // read data one cycle after the strobe, reserved bits as zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      if (addr == `PRIO_HI_ADDR) begin
        rdata_d = {3'h0, rif.hi_q};
      end else if (addr == `PRIO_LO_ADDR) begin
        rdata_d = {3'h0, rif.lo_q};
      end
    end
  end

  // level per source from the stored bits
  always_comb begin
    lvl_d = 10'h000;
    for (int i = 0; i < `PRIO_NUM_SRC; i++) begin
      lvl_d[2*i +: 2] = {rif.hi_q[i], rif.lo_q[i]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      lvl_q <= 10'h000;
    end else begin
      rdata_q <= rdata_d;
      lvl_q <= lvl_d;
    end
  end

  assign rdata = rdata_q;
  assign ext0_level = lvl_q[2*`PRIO_EXT0_BIT +: 2];
  assign timer0_level = lvl_q[2*`PRIO_TIMER0_BIT +: 2];
  assign ext1_level = lvl_q[2*`PRIO_EXT1_BIT +: 2];
  assign timer1_level = lvl_q[2*`PRIO_TIMER1_BIT +: 2];
  assign serial_level = lvl_q[2*`PRIO_SERIAL_BIT +: 2];
endmodule : interrupt_priority_config
`default_nettype wire

/* File: prio_map.svh */
// register map, field positions and reset values of the priority registers
// Overview of operation
// - level is high bit over low bit
// - low register bits: serial, t1, x1, t0, x0
// - low register at B8h, bit addressable, resets zero
// - high register at B7h, byte only, resets zero
`ifndef PRIO_MAP_SVH
`define PRIO_MAP_SVH
`define PRIO_HI_ADDR 8'hB7
`define PRIO_LO_ADDR 8'hB8
`define PRIO_RESET 5'h00
`define PRIO_EXT0_BIT 0
`define PRIO_TIMER0_BIT 1
`define PRIO_EXT1_BIT 2
`define PRIO_TIMER1_BIT 3
`define PRIO_SERIAL_BIT 4
`define PRIO_NUM_SRC 5
`define PRIO_BITSEL_W 3
`endif

/* File: prio_pkg.sv */
// types shared by the priority configuration block
package prio_pkg;
  typedef logic [1:0] level_t;
  typedef enum logic [1:0] {
    acc_none,
    acc_byte,
    acc_bit
  } access_e;
endpackage : prio_pkg

/* File: prio_reg_if.sv */
// carrier between the priority decoder and the bit store
`timescale 1ns/1ns
`default_nettype none
interface prio_reg_if;
  logic wr_hi;
  logic wr_lo;
  logic bit_wr_lo;
  logic [2:0] bit_sel;
  logic bit_val;
  logic [4:0] wdata;
  logic [4:0] hi_q;
  logic [4:0] lo_q;
  modport ctrl (output wr_hi, wr_lo, bit_wr_lo, bit_sel, bit_val, wdata, input hi_q, lo_q);
  modport store (input wr_hi, wr_lo, bit_wr_lo, bit_sel, bit_val, wdata, output hi_q, lo_q);
endinterface : prio_reg_if
`default_nettype wire

/* File: prio_store.sv */
// five-source low and high priority bit store
`timescale 1ns/1ns
`default_nettype none
`include "prio_map.svh"
module prio_store (
  input wire logic clk,
  input wire logic rst_n,
  prio_reg_if.store rif
);
  logic [4:0] hi_q;
  logic [4:0] hi_d;
  logic [4:0] lo_q;
  logic [4:0] lo_d;

  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    if (rif.wr_hi) begin
      hi_d = rif.wdata;
    end
    if (rif.wr_lo) begin
      lo_d = rif.wdata;
    end else if (rif.bit_wr_lo && rif.bit_sel < 3'(`PRIO_NUM_SRC)) begin
      lo_d[rif.bit_sel] = rif.bit_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= `PRIO_RESET;
      lo_q <= `PRIO_RESET;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign rif.hi_q = hi_q;
  assign rif.lo_q = lo_q;
endmodule : prio_store
`default_nettype wire

/* File: prio_check_assertions.sv */
// checker of the priority level block
`timescale 1ns/1ns
`default_nettype none
module prio_check (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [7:0] rdata,
  input wire logic [1:0] ext0_level,
  input wire logic [1:0] serial_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lo_byte:
    assert property (wr && addr == 8'hB8 |-> ##2 ext0_level[0] == $past(wdata[0], 2))
    else $error("lo write");
  a_hi_byte:
    assert property (wr && addr == 8'hB7 |-> ##2 serial_level[1] == $past(wdata[4], 2))
    else $error("hi write");
  a_lo_bit:
    assert property (bit_wr && !wr && addr == 8'hB8 && bit_sel == 3'h4
      |-> ##2 serial_level[0] == $past(bit_val, 2)) else $error("bit write");
  a_hi_readback:
    assert property (rd && addr == 8'hB7 |=> rdata[4] == serial_level[1]
      && rdata[0] == ext0_level[1]) else $error("level");
  a_hi_no_bit:
    assert property (!(wr && addr == 8'hB7) |-> ##2 $stable(serial_level[1]))
    else $error("hi change");
endmodule : prio_check
bind interrupt_priority_config prio_check chk (.*);
`default_nettype wire

/* File: tb_top.sv */
// bench of the priority level block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, bit_wr = 0, bit_val = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] bit_sel = 3'h0;
  logic [1:0] ext0_level, timer0_level, ext1_level, timer1_level, serial_level;
  int n_errors = 0, checks = 0;
  interrupt_priority_config uut (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .bit_wr(bit_wr),
    .bit_sel(bit_sel),
    .bit_val(bit_val),
    .rdata(rdata),
    .ext0_level(ext0_level),
    .timer0_level(timer0_level),
    .ext1_level(ext1_level),
    .timer1_level(timer1_level),
    .serial_level(serial_level)
  );
  initial forever #10 clk = ~clk;
  task cmp(logic [9:0] e, logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task put(logic [7:0] a, logic [7:0] d, logic b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bit_sel <= d[2:0];
    bit_val <= d[3];
    wr <= !b;
    bit_wr <= b;
    @(posedge clk);
    wr <= 0;
    bit_wr <= 0;
  endtask : put
  task get(logic [7:0] a, logic [9:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    cmp(e, {2'h0, rdata});
    @(negedge clk);
    cmp(10'h000, {2'h0, rdata});
  endtask : get
  task t_reset;
    cmp(10'h000, {serial_level, timer1_level, ext1_level, timer0_level, ext0_level});
    get(8'hB7, 10'h000);
    get(8'hB8, 10'h000);
  endtask : t_reset
  task t_levels;
    put(8'hB8, 8'h15, 0);
    put(8'hB7, 8'h0C, 0);
    get(8'hB7, 10'h00C);
    cmp(10'h1B1, {serial_level, timer1_level, ext1_level, timer0_level, ext0_level});
  endtask : t_levels
  task t_bits;
    put(8'hB8, 8'h09, 1);
    put(8'hB7, 8'h0C, 1);
    put(8'hB8, 8'h04, 1);
    get(8'hB8, 10'h007);
    get(8'hB7, 10'h00C);
    cmp(10'h0B5, {serial_level, timer1_level, ext1_level, timer0_level, ext0_level});
  endtask : t_bits
  task t_unmapped;
    put(8'hB9, 8'h1F, 0);
    put(8'hB6, 8'h1F, 0);
    get(8'hB9, 10'h000);
    get(8'hB8, 10'h007);
    get(8'hB7, 10'h00C);
    cmp(10'h0B5, {serial_level, timer1_level, ext1_level, timer0_level, ext0_level});
  endtask : t_unmapped
  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_levels;
    t_bits;
    t_unmapped;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
